// *** bench/cipc_host_model.sv ***
/* host side of the optional pins: pull-ups, override levels, user clock
   and a done-edge counter; assumes pad level = oe ? o : host level */
`timescale 1ns/1ps
`default_nettype none
module cipc_host_model (
  // clock
  input wire logic aclk,
  // pads
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_i,
  // host levels
  input wire logic run_clk,
  input wire logic oe_lvl,
  input wire logic clr_lvl,
  output logic [7:0] rises
);
  logic ck_q = 1'b0;
  logic was_q = 1'b1;
  logic [1:0] div_q = 2'h0;
  logic [7:0] cnt_q = 8'h00;
  logic [3:0] host;
  // user clock at aclk/8, still unless asked
  always_ff @(posedge aclk) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) begin
      ck_q <= run_clk & ~ck_q;
    end
  end
  // external pull-up holds init-done high when released
  assign host = {clr_lvl, oe_lvl, 1'b1, ck_q};
  // no test port on this side; host levels stay still while configuring
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & host);
  // completion is seen only as a low-to-high edge
  always_ff @(posedge aclk) begin
    // an unknown pad before reset counts as high, so leaving x is never counted as an edge
    was_q <= pin_i[1] !== 1'b0;
    cnt_q <= cnt_q + {7'h00, pin_i[1] & ~was_q};
  end
  assign rises = cnt_q;
endmodule : cipc_host_model
`default_nettype wire

// *** bench/tb_top.sv ***
/* bench for cipc_top, one task per scenario; assumes cipc_host_model
   on the optional pins and an axi4-lite master made of tasks */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic req_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wr, bv, arr, rv;
  logic [3:0] opt_i, opt_o, opt_oe, opt_pu;
  logic [3:0] c_out = 4'h0;
  logic [3:0] c_oe = 4'h0;
  logic [3:0] wstrb = 4'hf;
  logic [7:0] io_out = 8'ha5;
  logic [7:0] io_o, io_oe, rises;
  logic run_clk = 1'b0, oe_lvl = 1'b1, clr_lvl = 1'b1;
  logic um, urc, sck_oe, sdi_en, sel_oe, cmd_oe;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  cipc_top #(.NUM_IO(8), .FRAME_LEN(16'h0010)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .config_request_n(req_n),
    .config_serial_clock_o(), .config_serial_clock_oe(sck_oe),
    .config_serial_data_in(1'b1), .config_serial_data_in_en(sdi_en),
    .flash_select_n_o(), .flash_select_n_oe(sel_oe),
    .flash_command_out_o(), .flash_command_out_oe(cmd_oe),
    .opt_pin_i(opt_i), .opt_pin_o(opt_o), .opt_pin_oe(opt_oe),
    .opt_pull_up(opt_pu), .core_opt_out(c_out), .core_opt_oe(c_oe),
    .core_opt_in(), .io_pin_i(8'h00), .io_pin_o(io_o),
    .io_pin_oe(io_oe), .io_pull_up(), .core_io_out(io_out),
    .core_io_oe(8'hff), .core_io_in(), .user_mode(um),
    .user_register_clear(urc), .serial_data_sample()
  );
  cipc_host_model host (
    .aclk(aclk), .pin_o(opt_o), .pin_oe(opt_oe), .pin_i(opt_i),
    .run_clk(run_clk), .oe_lvl(oe_lvl), .clr_lvl(clr_lvl), .rises(rises)
  );
  initial begin
    forever #2 aclk = ~aclk;
  end
  // ---------
  // helpers
  // ---------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic nwait(input int n);
    repeat (n) @(negedge aclk);
  endtask : nwait
  // handshake values read mid-cycle are the ones the next edge samples
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    logic ta, tw, b;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (int i = 0; i < 60 && !b; i++) begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wr;
      b = bv;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    br <= 1'b0;
    chk("bvalid", 1, b);
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a);
    logic ta, b;
    b = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (int i = 0; i < 60 && !b; i++) begin
      @(negedge aclk);
      ta = arv && arr;
      b = rv;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
    end
    rr <= 1'b0;
    chk("rvalid", 1, b);
  endtask : axi_rd
  task automatic reconfig(input logic [4:0] c);
    axi_wr(cipc_pkg::ADDR_CTRL, {27'h0, c});
    axi_wr(cipc_pkg::ADDR_INIT, 32'h2);
    req_n <= 1'b0;
    repeat (2) @(posedge aclk);
    req_n <= 1'b1;
  endtask : reconfig
  task automatic wait_user();
    for (int i = 0; i < 300 && um !== 1'b1; i++) @(negedge aclk);
    chk("user_mode", 1, um);
  endtask : wait_user
  // ---------
  // scenarios
  // ---------
  task automatic t_regs();
    // a write with no byte lanes must leave the control word alone
    wstrb <= 4'h0;
    axi_wr(cipc_pkg::ADDR_CTRL, 32'h1f);
    wstrb <= 4'hf;
    axi_rd(12'h000);
    chk("ctrl", 32'h0, d);
    axi_rd(12'h008);
    chk("init", 32'h20, d);
    axi_rd(12'h00c);
    chk("rresp", 2'h2, r);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_done();
    reconfig(5'h0d);
    nwait(4);
    chk("opt_oe", 4'h0, opt_oe);
    chk("opt_pu", 4'hf, opt_pu);
    for (int i = 0; i < 40 && opt_oe[1] !== 1'b1; i++) @(negedge aclk);
    chk("done_low", 2'b10, {opt_oe[1], opt_i[1]});
    chk("early_user", 0, um);
    wait_user();
    nwait(2);
    chk("done_pad", 1, opt_i[1]);
    chk("rises", 1, rises);
    chk("sck_oe", 1, sck_oe);
    axi_rd(12'h004);
    chk("status", 5'h1f, d[4:0]);
    axi_wr(cipc_pkg::ADDR_STATUS, 32'h10);
    axi_rd(cipc_pkg::ADDR_STATUS);
    chk("status_clr", 5'h0f, d[4:0]);
    @(posedge aclk);
    oe_lvl <= 1'b0;
    nwait(3);
    chk("io_oe_off", 8'h00, io_oe);
    @(posedge aclk);
    oe_lvl <= 1'b1;
    nwait(3);
    chk("io_oe_on", 8'hff, io_oe);
    chk("io_o", 8'ha5, io_o);
    @(posedge aclk);
    clr_lvl <= 1'b0;
    nwait(3);
    chk("clear_on", 1, urc);
    @(posedge aclk);
    clr_lvl <= 1'b1;
    nwait(3);
    chk("clear_off", 0, urc);
    nwait(20);
    chk("done_held", 2'b01, {opt_oe[1], opt_i[1]});
    $display("t_done done");
  endtask : t_done
  task automatic t_astri();
    reconfig(5'h10);
    wait_user();
    nwait(2);
    chk("as_oe", 4'h0, {sck_oe, sdi_en, sel_oe, cmd_oe});
    @(posedge aclk);
    c_out <= 4'ha;
    c_oe <= 4'hf;
    io_out <= 8'h3c;
    oe_lvl <= 1'b0;
    nwait(3);
    chk("opt_user", 8'hfa, {opt_oe, opt_o});
    chk("no_gate", 8'hff, io_oe);
    chk("io_o_user", 8'h3c, io_o);
    @(posedge aclk);
    c_oe <= 4'h0;
    oe_lvl <= 1'b1;
    $display("t_astri done");
  endtask : t_astri
  task automatic t_uclk();
    reconfig(5'h02);
    nwait(60);
    chk("held_init", 0, um);
    @(posedge aclk);
    run_clk <= 1'b1;
    wait_user();
    $display("t_uclk done");
  endtask : t_uclk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_done();
    t_astri();
    t_uclk();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire

// *** design/cipc_init_timer.sv ***
/*
  initialization timer: counts ticks of either the system clock or of
  rising edges seen on the user start-up clock input; assumes that input
  is synchronous to aclk and slower than half its rate
*/
`timescale 1ns/1ps
`default_nettype none

module cipc_init_timer #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic use_user_clk,
  input wire logic user_clk_in,
  input wire logic [CNT_W-1:0] ticks,
  // status
  output logic done
);

  logic prev_q;
  logic [CNT_W-1:0] cnt_q;
  logic done_q;
  logic tick;

  // ----------------------------------------------------------------
  // tick select
  // ----------------------------------------------------------------
  assign tick = use_user_clk ? (user_clk_in & ~prev_q) : 1'b1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= user_clk_in;
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (tick && !done_q) begin
      cnt_q <= cnt_q + 1'b1;
      done_q <= (cnt_q + 1'b1) >= ticks;
    end
  end

  assign done = done_q;

  user_clk_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run && use_user_clk && !tick |=> cnt_q == $past(cnt_q))
    else $error("init counter moved without a user clock edge");

endmodule : cipc_init_timer

`default_nettype wire

// *** design/cipc_pin_ctrl.sv ***
/*
  per-pin output stage for a bank of pins that may be user or dedicated;
  assumes the pad adds the weak pull-up when pull_up is high
*/
`timescale 1ns/1ps
`default_nettype none

module cipc_pin_ctrl #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // mode
  input wire logic user_mode,
  input wire logic oe_gate,
  input wire logic [WIDTH-1:0] dedicated,
  // dedicated function drive
  input wire logic [WIDTH-1:0] ded_out,
  input wire logic [WIDTH-1:0] ded_oe,
  // core drive
  input wire logic [WIDTH-1:0] core_out,
  input wire logic [WIDTH-1:0] core_oe,
  // pads
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pull_up
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_o[g] <= 1'b0;
          pin_oe[g] <= 1'b0;
          pull_up[g] <= 1'b1;
        end else if (dedicated[g]) begin
          pin_o[g] <= ded_out[g];
          pin_oe[g] <= ded_oe[g];
          pull_up[g] <= 1'b0;
        end else if (!user_mode) begin
          // not yet configured: float high, never drive
          pin_o[g] <= 1'b0;
          pin_oe[g] <= 1'b0;
          pull_up[g] <= 1'b1;
        end else begin
          pin_o[g] <= core_out[g];
          pin_oe[g] <= core_oe[g] & ~oe_gate;
          pull_up[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : cipc_pin_ctrl

`default_nettype wire

// *** design/cipc_pkg.sv ***
/*
  shared constants, states and carriers of the configuration pin control
  block; assumes a 32-bit AXI4-Lite register bus with byte addressing
*/
package cipc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_INIT = 12'h008;

  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [15:0] INIT_TICKS_RESET = 16'h0020;

  localparam int ST_STATE_LSB = 0;
  localparam int ST_USER_BIT = 2;
  localparam int ST_DONE_PIN_BIT = 3;
  localparam int ST_DONE_RISE_BIT = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [15:0] FRAME_CYCLES = 16'h0010;

  // ----------------------------------------------------------------
  // optional pin slots
  // ----------------------------------------------------------------
  localparam int OPT_PINS = 4;
  localparam int IDX_STARTUP_CLK = 0;
  localparam int IDX_INIT_DONE = 1;
  localparam int IDX_OUTPUT_ENABLE = 2;
  localparam int IDX_REGISTER_CLEAR = 3;

  // ----------------------------------------------------------------
  // serial flash pins when idle
  // ----------------------------------------------------------------
  localparam logic AS_CLK_IDLE = 1'b0;
  localparam logic AS_SEL_IDLE = 1'b1;
  localparam logic AS_CMD_IDLE = 1'b1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CIPC_RESET,
    CIPC_CONFIG,
    CIPC_INIT,
    CIPC_USER
  } cipc_state_t;

  typedef struct packed {
    logic as_tristate;
    logic clr_override;
    logic oe_override;
    logic user_clk;
    logic init_done;
  } cipc_opt_t;

endpackage : cipc_pkg

// *** design/cipc_top.sv ***
/*
  configuration pin control: configuration sequencing, the open-drain
  init-done flag, the global output-enable and register-clear overrides,
  the serial flash pins and the optional pins; assumes an AXI4-Lite master
  and pads that resolve level from output and enable
*/
`timescale 1ns/1ps
`default_nettype none

// Operation
// - disabled optional pins stay tri-stated with pull-up during configuration
// - tri-state option floats serial clock, data, select, command in user mode
// - user clock option makes initialization count user clock edges
// - init-done floats while configuration request low and at config start
// - init-done drives low once its option loads from first frame
// - init-done released at end of initialization, one cycle after user mode
// - global output enable low floats all I/O when override enabled
// - global clear low clears all registers when override enabled
// - disabled optional pins serve as user I/O in user mode
module cipc_top #(
  parameter int NUM_IO = 8,
  parameter logic [15:0] FRAME_LEN = cipc_pkg::FRAME_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [cipc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [cipc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration request
  input wire logic config_request_n,
  // serial flash pins
  output logic config_serial_clock_o,
  output logic config_serial_clock_oe,
  input wire logic config_serial_data_in,
  output logic config_serial_data_in_en,
  output logic flash_select_n_o,
  output logic flash_select_n_oe,
  output logic flash_command_out_o,
  output logic flash_command_out_oe,
  // optional pins
  input wire logic [cipc_pkg::OPT_PINS-1:0] opt_pin_i,
  output logic [cipc_pkg::OPT_PINS-1:0] opt_pin_o,
  output logic [cipc_pkg::OPT_PINS-1:0] opt_pin_oe,
  output logic [cipc_pkg::OPT_PINS-1:0] opt_pull_up,
  input wire logic [cipc_pkg::OPT_PINS-1:0] core_opt_out,
  input wire logic [cipc_pkg::OPT_PINS-1:0] core_opt_oe,
  output logic [cipc_pkg::OPT_PINS-1:0] core_opt_in,
  // user i/o bank
  input wire logic [NUM_IO-1:0] io_pin_i,
  output logic [NUM_IO-1:0] io_pin_o,
  output logic [NUM_IO-1:0] io_pin_oe,
  output logic [NUM_IO-1:0] io_pull_up,
  input wire logic [NUM_IO-1:0] core_io_out,
  input wire logic [NUM_IO-1:0] core_io_oe,
  output logic [NUM_IO-1:0] core_io_in,
  // core status
  output logic user_mode,
  output logic user_register_clear,
  output logic serial_data_sample
);

  cipc_pkg::cipc_state_t state_q;
  cipc_pkg::cipc_opt_t ctrl_q;
  cipc_pkg::cipc_opt_t opt_q;
  logic [15:0] init_ticks_q;
  logic [15:0] frame_cnt_q;
  logic timer_done;
  logic done_rise_q;
  logic done_oe_prev_q;
  logic done_rise;
  logic oe_gate;
  logic [cipc_pkg::OPT_PINS-1:0] opt_ded;
  logic [cipc_pkg::OPT_PINS-1:0] opt_ded_oe;
  logic user_startup_clock_in;
  logic global_output_enable;
  logic global_register_clear_n;
  logic aw_have_q;
  logic w_have_q;
  logic [cipc_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic status_clr;
  logic [31:0] rd_word;
  logic rd_hit;
  logic ser_clk_q;
  logic sample_q;

  assign user_startup_clock_in = opt_pin_i[cipc_pkg::IDX_STARTUP_CLK];
  assign global_output_enable = opt_pin_i[cipc_pkg::IDX_OUTPUT_ENABLE];
  assign global_register_clear_n = opt_pin_i[cipc_pkg::IDX_REGISTER_CLEAR];
  assign core_opt_in = opt_pin_i;
  assign core_io_in = io_pin_i;

  // ----------------------------------------------------------------
  // configuration sequence
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !config_request_n) begin
      state_q <= cipc_pkg::CIPC_RESET;
    end else begin
      case (state_q)
        cipc_pkg::CIPC_RESET: state_q <= cipc_pkg::CIPC_CONFIG;
        cipc_pkg::CIPC_CONFIG: begin
          if (frame_cnt_q == FRAME_LEN - 16'h0001) begin
            state_q <= cipc_pkg::CIPC_INIT;
          end
        end
        cipc_pkg::CIPC_INIT: begin
          if (timer_done) begin
            state_q <= cipc_pkg::CIPC_USER;
          end
        end
        default: state_q <= cipc_pkg::CIPC_USER;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != cipc_pkg::CIPC_CONFIG) begin
      frame_cnt_q <= '0;
    end else begin
      frame_cnt_q <= frame_cnt_q + 16'h0001;
    end
  end

  // options become live only once the first frame has been taken in
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q == cipc_pkg::CIPC_RESET) begin
      opt_q <= cipc_pkg::CTRL_RESET;
    end else if (state_q == cipc_pkg::CIPC_CONFIG &&
                 frame_cnt_q == FRAME_LEN - 16'h0001) begin
      opt_q <= ctrl_q;
    end
  end

  cipc_init_timer #(
    .CNT_W(16)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(state_q == cipc_pkg::CIPC_INIT),
    .use_user_clk(opt_q.user_clk),
    .user_clk_in(user_startup_clock_in),
    .ticks(init_ticks_q),
    .done(timer_done)
  );

  assign user_mode = state_q == cipc_pkg::CIPC_USER;

  // ----------------------------------------------------------------
  // optional pins and user i/o
  // ----------------------------------------------------------------
  assign oe_gate = opt_q.oe_override & ~global_output_enable;
  assign opt_ded = {opt_q.clr_override, opt_q.oe_override,
                    opt_q.init_done, opt_q.user_clk};
  assign opt_ded_oe = {2'b00,
                       opt_q.init_done & state_q == cipc_pkg::CIPC_INIT,
                       1'b0};

  cipc_pin_ctrl #(
    .WIDTH(cipc_pkg::OPT_PINS)
  ) u_opt_pins (
    .aclk(aclk),
    .aresetn(aresetn),
    .user_mode(user_mode),
    .oe_gate(oe_gate),
    .dedicated(opt_ded),
    .ded_out('0),
    .ded_oe(opt_ded_oe),
    .core_out(core_opt_out),
    .core_oe(core_opt_oe),
    .pin_o(opt_pin_o),
    .pin_oe(opt_pin_oe),
    .pull_up(opt_pull_up)
  );

  cipc_pin_ctrl #(
    .WIDTH(NUM_IO)
  ) u_io_pins (
    .aclk(aclk),
    .aresetn(aresetn),
    .user_mode(user_mode),
    .oe_gate(oe_gate),
    .dedicated('0),
    .ded_out('0),
    .ded_oe('0),
    .core_out(core_io_out),
    .core_oe(core_io_oe),
    .pin_o(io_pin_o),
    .pin_oe(io_pin_oe),
    .pull_up(io_pull_up)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      user_register_clear <= 1'b0;
    end else begin
      user_register_clear <= opt_q.clr_override & ~global_register_clear_n;
    end
  end

  // ----------------------------------------------------------------
  // serial flash pins
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_clk_q <= cipc_pkg::AS_CLK_IDLE;
      sample_q <= 1'b0;
      config_serial_clock_oe <= 1'b1;
      flash_select_n_o <= cipc_pkg::AS_SEL_IDLE;
      flash_select_n_oe <= 1'b1;
      flash_command_out_o <= cipc_pkg::AS_CMD_IDLE;
      flash_command_out_oe <= 1'b1;
      config_serial_data_in_en <= 1'b1;
    end else begin
      ser_clk_q <= (state_q == cipc_pkg::CIPC_CONFIG) ? ~ser_clk_q
                                                      : cipc_pkg::AS_CLK_IDLE;
      if (state_q == cipc_pkg::CIPC_CONFIG && !ser_clk_q) begin
        sample_q <= config_serial_data_in;
      end
      flash_select_n_o <= (state_q == cipc_pkg::CIPC_CONFIG) ? 1'b0
                                                  : cipc_pkg::AS_SEL_IDLE;
      flash_command_out_o <= (state_q == cipc_pkg::CIPC_CONFIG) ? 1'b0
                                                  : cipc_pkg::AS_CMD_IDLE;
      config_serial_clock_oe <= ~(user_mode & opt_q.as_tristate);
      flash_select_n_oe <= ~(user_mode & opt_q.as_tristate);
      flash_command_out_oe <= ~(user_mode & opt_q.as_tristate);
      config_serial_data_in_en <= ~(user_mode & opt_q.as_tristate);
    end
  end

  assign config_serial_clock_o = ser_clk_q;
  assign serial_data_sample = sample_q;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign status_clr = do_write && awaddr_q == cipc_pkg::ADDR_STATUS &&
                      wstrb_q[0] && wdata_q[cipc_pkg::ST_DONE_RISE_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= cipc_pkg::CTRL_RESET;
      init_ticks_q <= cipc_pkg::INIT_TICKS_RESET;
    end else if (do_write) begin
      if (awaddr_q == cipc_pkg::ADDR_CTRL && wstrb_q[0]) begin
        ctrl_q <= wdata_q[4:0];
      end
      if (awaddr_q == cipc_pkg::ADDR_INIT) begin
        if (wstrb_q[0]) init_ticks_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) init_ticks_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cipc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_q == cipc_pkg::ADDR_CTRL ||
                      awaddr_q == cipc_pkg::ADDR_STATUS ||
                      awaddr_q == cipc_pkg::ADDR_INIT) ?
                     cipc_pkg::RESP_OKAY : cipc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // sticky edge of the released flag as the outside sees it
  assign done_rise = done_oe_prev_q & ~opt_pin_oe[cipc_pkg::IDX_INIT_DONE];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_oe_prev_q <= 1'b0;
      done_rise_q <= 1'b0;
    end else begin
      done_oe_prev_q <= opt_pin_oe[cipc_pkg::IDX_INIT_DONE];
      if (done_rise) begin
        done_rise_q <= 1'b1;
      end else if (status_clr) begin
        done_rise_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (s_axi_araddr == cipc_pkg::ADDR_CTRL) begin
      rd_word[4:0] = ctrl_q;
    end else if (s_axi_araddr == cipc_pkg::ADDR_STATUS) begin
      rd_word[cipc_pkg::ST_STATE_LSB +: 2] = state_q;
      rd_word[cipc_pkg::ST_USER_BIT] = user_mode;
      rd_word[cipc_pkg::ST_DONE_PIN_BIT] =
        ~opt_pin_oe[cipc_pkg::IDX_INIT_DONE];
      rd_word[cipc_pkg::ST_DONE_RISE_BIT] = done_rise_q;
    end else if (s_axi_araddr == cipc_pkg::ADDR_INIT) begin
      rd_word[15:0] = init_ticks_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= cipc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? cipc_pkg::RESP_OKAY : cipc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  request_float_a: assert property (
    !config_request_n [*2] |=> !opt_pin_oe[cipc_pkg::IDX_INIT_DONE])
    else $error("init-done driven while configuration requested");
  done_low_a: assert property (
    state_q == cipc_pkg::CIPC_INIT && opt_q.init_done |=>
    opt_pin_oe[cipc_pkg::IDX_INIT_DONE] && !opt_pin_o[cipc_pkg::IDX_INIT_DONE])
    else $error("init-done not driven low during initialization");
  init_to_user_a: assert property (
    state_q == cipc_pkg::CIPC_INIT && timer_done && config_request_n |=>
    state_q == cipc_pkg::CIPC_USER ##1
    (!opt_q.init_done || !opt_pin_oe[cipc_pkg::IDX_INIT_DONE]))
    else $error("no user mode with released flag after initialization");
  user_stays_a: assert property (
    user_mode && config_request_n |=> user_mode &&
    (!opt_q.init_done || !opt_pin_oe[cipc_pkg::IDX_INIT_DONE]))
    else $error("user mode left or flag driven without request");
  oe_gate_a: assert property (
    oe_gate |=> io_pin_oe == '0)
    else $error("user i/o driven while output enable override low");
  reg_clear_a: assert property (
    opt_q.clr_override && !global_register_clear_n |=> user_register_clear)
    else $error("register clear not applied");
  config_float_a: assert property (
    !user_mode |=> io_pin_oe == '0 && &io_pull_up)
    else $error("user i/o not floated with pull-up before user mode");
  as_tristate_a: assert property (
    user_mode && opt_q.as_tristate |=> !config_serial_clock_oe &&
    !flash_select_n_oe && !flash_command_out_oe && !config_serial_data_in_en)
    else $error("serial flash pins still active in user mode");
  opt_user_io_a: assert property (
    user_mode && !opt_q.oe_override && !oe_gate |=>
    opt_pin_oe[cipc_pkg::IDX_OUTPUT_ENABLE] ==
    $past(core_opt_oe[cipc_pkg::IDX_OUTPUT_ENABLE]))
    else $error("disabled optional pin not acting as user i/o");

  reach_user_c: cover property (state_q == cipc_pkg::CIPC_INIT ##1 user_mode);
  done_edge_c: cover property (done_rise);
  gate_on_c: cover property (user_mode && oe_gate);
  clear_on_c: cover property (user_register_clear);

endmodule : cipc_top

`default_nettype wire
